// *** design/lassr_pkg.sv ***
// Shared constants and carrier types for the linear array scan sequencer.
// Assumes a single 100 MHz clock domain and a synchronous active-high reset.
package lassr_pkg;

  // ----------------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------------
  localparam int LASSR_PIX_DEFAULT  = 128;
  localparam int LASSR_DUMMY_SIDE   = 2;
  localparam int LASSR_DUMMY_TOTAL  = 2 * LASSR_DUMMY_SIDE;
  localparam int LASSR_MAX_STAGES   = 512 + LASSR_DUMMY_TOTAL;
  localparam int LASSR_IDX_W        = $clog2(LASSR_MAX_STAGES);

  // ----------------------------------------------------------------------
  // Sample kinds on the video line
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    LASSR_KIND_NONE  = 2'h0,
    LASSR_KIND_DARK  = 2'h1,
    LASSR_KIND_DUMMY = 2'h2,
    LASSR_KIND_IMAGE = 2'h3
  } lassr_kind_t;

  typedef struct packed {
    logic                   valid;
    lassr_kind_t            kind;
    logic [LASSR_IDX_W-1:0] index;
  } lassr_sample_t;

endpackage : lassr_pkg

// *** design/lassr_pixel_cell.sv ***
// One pixel cell: integrates charge while its read switch is open and
// dumps the held charge onto the shared video line when selected.
// Assumes charge arrives as a per-cycle increment from the analog model.
`timescale 1ns/1ps
module lassr_pixel_cell
  import lassr_pkg::*;
#(
  parameter int CHG_W = 16
)
(
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             clkEn,
  input  wire logic             readSel,
  input  wire logic [CHG_W-1:0] chargeIn,
  output logic      [CHG_W-1:0] chargeOut
);

  logic [CHG_W-1:0] stored;

  // Integrate while open, restart from the new increment on read
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      stored <= '0;
    else if (clkEn)
    begin
      if (readSel)
        stored <= chargeIn;
      else if (stored > ~chargeIn)
        stored <= '1;
      else
        stored <= stored + chargeIn;
    end
  end

  assign chargeOut = readSel ? stored : '0;

endmodule : lassr_pixel_cell

// *** design/lassr_scan.sv ***
// Self-scanning readout sequencer of a linear photodiode array.
// Assumes the start input and charge increments are synchronous to clock.
//
// How it works
// RULE_01 - A scan begins only on start; otherwise every read switch stays open.
// RULE_02 - A single token walks the stages in array order, one per clock.
// RULE_03 - Open pixels integrate; a closed switch puts its charge on the video line.
// RULE_04 - Imaging pixel count is a build parameter: 128, 256 or 512.
// RULE_05 - Scan adds four dummies: dark and imaging dummy at each end.
// RULE_06 - Scan-done output is high exactly one clock when last dummy reads.
// RULE_07 - After scan done, a new start restarts the register at stage one.
// RULE_08 - Controller supplies a continuous clock and the start pulse only.
// RULE_09 - Start is sampled on the clock; one sampled edge launches one scan. Code samples the level: start held high relaunches after each scan.
// RULE_10 - Controller expects pixel count plus four samples, then the done pulse.
`timescale 1ns/1ps
module lassr_scan
  import lassr_pkg::*;
#(
  parameter int PIX_COUNT = LASSR_PIX_DEFAULT,
  parameter int CHG_W     = 16
)
(
  input  wire logic                                       clock,
  input  wire logic                                       sys_rst,
  input  wire logic                                       clkEn,
  input  wire logic                                       scanStart,
  input  wire logic [PIX_COUNT+LASSR_DUMMY_TOTAL-1:0][CHG_W-1:0] chargeIn,
  output logic      [CHG_W-1:0]                           video_charge_line,
  output lassr_sample_t                                   videoTag,
  output logic                                            scan_done_pulse,
  output logic                                            scanBusy
);

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int STAGES = PIX_COUNT + LASSR_DUMMY_TOTAL; // see RULE_04 see RULE_05

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_SCAN
  } lassr_state_t;

  lassr_state_t        state;
  logic [STAGES-1:0]   token;
  logic [CHG_W-1:0]    cellOut [STAGES];
  logic [CHG_W-1:0]    next_video;
  lassr_sample_t       next_tag;

  // ----------------------------------------------------------------------
  // Scan control and token shift register
  // ----------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state <= ST_IDLE;
      token <= '0;
    end
    else if (clkEn)
    begin
      case (state)
        ST_IDLE:
        begin
          if (scanStart) // see RULE_01 see RULE_09
          begin
            token <= {{(STAGES-1){1'b0}}, 1'b1}; // see RULE_07
            state <= ST_SCAN;
          end
        end
        ST_SCAN:
        begin
          token <= token << 1; // see RULE_02
          if (token[STAGES-1])
            state <= ST_IDLE;
        end
        default:
        begin
          state <= ST_IDLE;
          token <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Pixel cells, one per stage
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < STAGES; g++)
    begin : gCell
      lassr_pixel_cell #(
        .CHG_W     (CHG_W)
      ) uCell (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .clkEn     (clkEn),
        .readSel   (token[g]),    // see RULE_03
        .chargeIn  ((g < LASSR_DUMMY_SIDE - 1 || g > STAGES - LASSR_DUMMY_SIDE)
                    ? '0 : chargeIn[g]),
        .chargeOut (cellOut[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Video line mux and sample tag
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_video = '0;
    next_tag   = '0;
    for (int i = 0; i < STAGES; i++)
    begin
      next_video = next_video | cellOut[i]; // see RULE_03
      if (token[i])
      begin
        next_tag.valid = 1'b1;
        next_tag.index = LASSR_IDX_W'(i);
        if (i == 0 || i == STAGES - 1)
          next_tag.kind = LASSR_KIND_DARK;
        else if (i == 1 || i == STAGES - 2)
          next_tag.kind = LASSR_KIND_DUMMY;
        else
          next_tag.kind = LASSR_KIND_IMAGE;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      video_charge_line <= '0;
      videoTag          <= '0;
    end
    else if (clkEn)
    begin
      video_charge_line <= next_video; // see RULE_10
      videoTag          <= next_tag;
    end
  end

  // ----------------------------------------------------------------------
  // End of scan and busy flags
  // ----------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      scan_done_pulse <= 1'b0;
      scanBusy        <= 1'b0;
    end
    else if (clkEn)
    begin
      scan_done_pulse <= (state == ST_SCAN) && token[STAGES-1]; // see RULE_06
      scanBusy        <= (state == ST_SCAN) ? !token[STAGES-1] : scanStart;
    end
  end

endmodule : lassr_scan

// *** test/lassr_scan_checker.sv ***
// Checker for the scan sequencer outputs, bound to lassr_scan.
// Assumes clkEn stays high, so every clock edge advances the scan.
`timescale 1ns/1ps
module lassr_scan_checker
  import lassr_pkg::*;
#(
  parameter int PIX_COUNT = LASSR_PIX_DEFAULT,
  parameter int CHG_W     = 16
)
(
  input wire logic             clock,
  input wire logic             sys_rst,
  input wire logic             scanStart,
  input wire logic [CHG_W-1:0] video_charge_line,
  input wire lassr_sample_t    videoTag,
  input wire logic             scan_done_pulse,
  input wire logic             scanBusy
);
  localparam int LAST = PIX_COUNT + 3;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence scan_take;
    !scanBusy && scanStart;
  endsequence
  sequence first_out;
    ##2 videoTag.valid && videoTag.index == 0;
  endsequence
  start_launch_a: assert property (scan_take |-> first_out)
    else $error("scan did not launch");
  no_start_a: assert property (!scanBusy && !scanStart |=> !scanBusy)
    else $error("busy without start");
  idle_zero_a: assert property (!videoTag.valid |-> video_charge_line == 0)
    else $error("video not zero when idle");
  index_step_a: assert property (videoTag.valid && videoTag.index != LAST |=>
    videoTag.valid && videoTag.index == $past(videoTag.index) + 1)
    else $error("index did not step");
  first_index_a: assert property ($rose(videoTag.valid) |-> videoTag.index == 0)
    else $error("scan did not begin at stage one");
  kind_map_a: assert property (videoTag.valid |-> videoTag.kind ==
    ((videoTag.index == 0 || videoTag.index == LAST) ? LASSR_KIND_DARK :
     (videoTag.index == 1 || videoTag.index == LAST - 1) ? LASSR_KIND_DUMMY : LASSR_KIND_IMAGE))
    else $error("wrong sample kind");
  dark_zero_a: assert property (videoTag.valid && videoTag.kind == LASSR_KIND_DARK |->
    video_charge_line == 0)
    else $error("dark dummy carried charge");
  done_tag_a: assert property (scan_done_pulse |-> videoTag.valid && videoTag.index == LAST)
    else $error("done not on last sample");
  done_once_a: assert property (scan_done_pulse |=> !scan_done_pulse)
    else $error("done longer than one cycle");
endmodule : lassr_scan_checker

bind lassr_scan lassr_scan_checker #(.PIX_COUNT(PIX_COUNT), .CHG_W(CHG_W)) chk (
  .clock(clock), .sys_rst(sys_rst), .scanStart(scanStart),
  .video_charge_line(video_charge_line), .videoTag(videoTag),
  .scan_done_pulse(scan_done_pulse), .scanBusy(scanBusy));

// *** test/lassr_ctrl_model.sv ***
// Controller model: start held high, or one start pulse after each done.
// Assumes the bench supplies the free-running clock and the mode.
`timescale 1ns/1ps
module lassr_ctrl_model
(
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic holdHigh,
  input  wire logic scan_done_pulse,
  output logic      scanStart
);
  logic doneSeen = 1'b0;
  initial scanStart = 1'b0;
  always @(negedge clock)
  begin
    doneSeen  <= scan_done_pulse;
    scanStart <= !sys_rst && (holdHigh || doneSeen);
  end
endmodule : lassr_ctrl_model

// *** test/testbench.sv ***
// Bench: controller model starts scans, samples compared with a queue model.
// Assumes a 128 pixel build with the checker bound to it.
`timescale 1ns/1ps
module testbench;
  import lassr_pkg::*;
  localparam int N = 128;
  logic clock = 0, sys_rst = 1, holdHigh = 1, done, busy, scanStart;
  logic [N+LASSR_DUMMY_TOTAL-1:0][15:0] chargeIn;
  logic [15:0] video;
  lassr_sample_t tag;
  int err_total = 0, cmp_count = 0, seed = 32'h1156, dones = 0, samples = 0, q[$];
  always #5 clock = ~clock;
  lassr_scan #(.PIX_COUNT(N)) uut (.clock(clock), .sys_rst(sys_rst), .clkEn(1'b1),
    .scanStart(scanStart), .chargeIn(chargeIn), .video_charge_line(video),
    .videoTag(tag), .scan_done_pulse(done), .scanBusy(busy));
  lassr_ctrl_model ctrl (.clock(clock), .sys_rst(sys_rst), .holdHigh(holdHigh),
    .scan_done_pulse(done), .scanStart(scanStart));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task conclude;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  function automatic logic [1:0] kindOf(input int i);
    return (i == 0 || i == N + 3) ? 2'h1 : (i == 1 || i == N + 2) ? 2'h2 : 2'h3;
  endfunction : kindOf
  always @(negedge clock)
    foreach (chargeIn[i]) chargeIn[i] <= 16'($random(seed)) & 16'h00FF;
  always @(posedge clock)
    if (!sys_rst && tag.valid)
    begin
      if (q.size() == 0) for (int i = 0; i < N + 4; i++) q.push_back(i);
      chk(tag.index, q[0]);
      chk(tag.kind, kindOf(q[0]));
      chk(done, q[0] == N + 3);
      if (q[0] == 0 || q[0] == N + 3) chk(video, 16'h0000);
      void'(q.pop_front());
      samples++;
      if (done) dones++;
    end
  // Reference of charge, busy and valid, one cycle ahead of the registered outputs
  int acc[N+4], tk = -1, expVid = 0, expBusy = 0, expValid = 0, chg;
  always @(posedge clock)
    if (sys_rst)
    begin
      tk = -1;
      expVid = 0;
      expBusy = 0;
      expValid = 0;
      foreach (acc[i]) acc[i] = 0;
    end
    else
    begin
      chk(video, expVid);
      chk(busy, expBusy);
      chk(tag.valid, expValid);
      expValid = tk >= 0;
      expVid = (tk >= 0) ? acc[tk] : 0;
      expBusy = (tk < 0) ? scanStart : tk < N + 3;
      foreach (acc[i])
      begin
        chg = (i == 0 || i == N + 3) ? 0 : chargeIn[i];
        acc[i] = (i == tk) ? chg : (acc[i] + chg > 65535) ? 65535 : acc[i] + chg;
      end
      tk = (tk < 0) ? (scanStart ? 0 : -1) : (tk < N + 3) ? tk + 1 : -1;
    end
  initial
  begin
    chargeIn = '0;
    repeat (2) @(posedge clock);
    @(negedge clock) sys_rst = 0;
    wait (dones >= 2);
    @(negedge clock) holdHigh = 0;
    wait (dones >= 4);
    repeat (3) @(posedge clock);
    chk(samples, 4 * (N + 4));
    conclude();
  end
  initial
  begin
    #20000;
    err_total++;
    conclude();
  end
endmodule : testbench
